/* File: rtl/tcsv_defs.vh */
`ifndef TCSV_DEFS_VH
`define TCSV_DEFS_VH
// Register offsets (byte registers, low byte of the data bus)
`define TCSV_OFF_SC      8'h05
`define TCSV_OFF_VH      8'h06
`define TCSV_OFF_VL      8'h07
`define TCSV_CH_STRIDE   8'h03
`define TCSV_OFF_CTRL    8'h20
`define TCSV_OFF_UPD     8'h21
// Status/control field positions
`define TCSV_SC_FLAG     7
`define TCSV_SC_IE       6
`define TCSV_SC_MSB      5
`define TCSV_SC_MSA      4
`define TCSV_SC_EDGE_LEVEL_SEL_HI     3
`define TCSV_SC_EDGE_LEVEL_SEL_LO     2
// Module control field positions
`define TCSV_CT_WRITE_PROTECT_DISABLE    0
`define TCSV_CT_ENHANCED_FEATURES_ENABLE    1
`define TCSV_CT_DECAP    2
`define TCSV_CT_CAPTEST  3
// Reset values
`define TCSV_SC_RST      8'h00
`define TCSV_CTRL_RST    8'h01
`define TCSV_VAL_RST     16'h0000
`endif

/* File: rtl/tcsv_channel.v */
// Notes on behaviour
// - Capture or compare event sets the channel event flag, bit 7.
// - Flag clears only by reading it set, then writing 0 to it.
// - Writing 1 to the flag leaves it unchanged.
// - Event between the read and clearing write cancels that clear.
// - Bit 6 enables the channel interrupt request; 0 means polling.
// - Mode and edge/level bits write only while write-protect-disable is 1.
// - Bits 1 and 0 of status/control always read 0.
// - In capture modes reading one value byte latches both until other byte read.
// - Any status/control write releases the value read latch.
// - Value byte writes ignored in capture modes.
// - Background debug freezes read latch state even on reads.
// - Debug reads of value bytes return live value, not buffer.
// - Output mode writes go to a buffer, loaded on update strobe, or at once with enhanced features off.
// - With enhanced features off, status/control write resets write sequence.
// - Background debug freezes write coherency latches; only status/control writes with enhanced features off reset them.
// - Debug value writes bypass the buffer and hit the value directly.
// - Values written during debug are used after debug ends.
// - Debug writes do not disturb an unfinished byte-pair write.
// - Completed pair updates value from bytes buffered outside debug.
// - Value holds captured count in capture modes, match value otherwise.
// - High value byte at 6h plus 3 times channel index, index 0 to 5.
// - Edge/level 00 disconnects pin; capture edges and compare actions decoded.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tcsv_defs.vh"
module tcsv_channel #(
    parameter CH_INDEX = 0,
    parameter CNT_W = 16
) (
    // Clock and reset
    input wire SYS_CLK_IN,
    input wire RSTN_IN,
    // Register port
    input wire [7:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [7:0] RDATA_OUT,
    // Timer side
    input wire [CNT_W-1:0] COUNT_IN,
    input wire EVENT_IN,
    input wire BDM_IN,
    input wire CH_PIN_IN,
    // Status outputs
    output reg IRQ_OUT,
    output reg [CNT_W-1:0] MATCH_OUT,
    output reg PIN_EN_OUT,
    output reg CAP_MODE_OUT,
    output reg [1:0] CMP_ACTION_OUT,
    output reg [1:0] CAP_EDGES_OUT
);
    // Offsets are worked out wide, then cut to the byte address on purpose
    localparam integer OFF_SC_I = `TCSV_OFF_SC + CH_INDEX * `TCSV_CH_STRIDE;
    localparam integer OFF_VH_I = `TCSV_OFF_VH + CH_INDEX * `TCSV_CH_STRIDE;
    localparam integer OFF_VL_I = `TCSV_OFF_VL + CH_INDEX * `TCSV_CH_STRIDE;
    localparam [7:0] OFF_SC = OFF_SC_I[7:0];
    localparam [7:0] OFF_VH = OFF_VH_I[7:0];
    localparam [7:0] OFF_VL = OFF_VL_I[7:0];

    reg [7:0] sc_reg;
    reg [7:0] ctrl_reg;
    reg [15:0] val_reg;
    reg [15:0] rbuf_reg;
    reg rlat_reg;
    reg [15:0] wbuf_reg;
    reg wh_reg;
    reg wl_reg;
    reg wpend_reg;
    reg armed_reg;
    reg evt_since_rd_reg;
    reg bdm_m_reg;
    reg bdm_reg;
    reg pin_m_reg;
    reg pin_s_reg;
    reg pin_d_reg;
    reg evt_m_reg;
    reg evt_s_reg;
    // Remembers which byte opened the read pair
    reg rlat_hi_reg;

    // Next values of the state above
    reg [7:0] sc_next;
    reg armed_next;
    reg evt_since_rd_next;
    reg [15:0] val_next;
    reg [15:0] rbuf_next;
    reg rlat_next;
    reg rlat_hi_next;
    reg [15:0] wbuf_next;
    reg wh_next;
    reg wl_next;
    reg wpend_next;
    reg [7:0] rdata_next;
    reg irq_next;
    reg pin_en_next;
    reg [1:0] cmp_action_next;
    reg [1:0] cap_edges_next;

    wire wp_dis = ctrl_reg[`TCSV_CT_WRITE_PROTECT_DISABLE];
    wire ftm_en = ctrl_reg[`TCSV_CT_ENHANCED_FEATURES_ENABLE];
    wire upd_wr = WR_IN && (ADDR_IN == `TCSV_OFF_UPD);
    wire sc_wr = WR_IN && (ADDR_IN == OFF_SC);
    wire sc_rd = RD_IN && (ADDR_IN == OFF_SC);
    wire vh_wr = WR_IN && (ADDR_IN == OFF_VH);
    wire vl_wr = WR_IN && (ADDR_IN == OFF_VL);
    wire vh_rd = RD_IN && (ADDR_IN == OFF_VH);
    wire vl_rd = RD_IN && (ADDR_IN == OFF_VL);
    wire v_rd = vh_rd || vl_rd;

    // Capture family: input capture, capture test or dual edge capture
    function is_capture;
        input [7:0] sc;
        input [7:0] ct;
        begin
            is_capture = (ct[`TCSV_CT_CAPTEST]) || (ct[`TCSV_CT_DECAP]) ||
                         (sc[`TCSV_SC_MSB:`TCSV_SC_MSA] == 2'b00 &&
                          sc[`TCSV_SC_EDGE_LEVEL_SEL_HI:`TCSV_SC_EDGE_LEVEL_SEL_LO] != 2'b00);
        end
    endfunction

    wire cap_mode = is_capture(sc_reg, ctrl_reg);

    // Edge detect on the synchronised pin
    wire rise = pin_s_reg && !pin_d_reg;
    wire fall = !pin_s_reg && pin_d_reg;
    wire edge_hit = (sc_reg[`TCSV_SC_EDGE_LEVEL_SEL_LO] && rise) || (sc_reg[`TCSV_SC_EDGE_LEVEL_SEL_HI] && fall);
    wire cap_evt = cap_mode && edge_hit;
    wire cmp_evt = !cap_mode && (COUNT_IN[15:0] == val_reg) && evt_s_reg;
    wire any_evt = cap_evt || cmp_evt;

    // Two-flop synchronisers for pin, event strobe and debug level
    always @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pin_m_reg <= 1'b0;
            pin_s_reg <= 1'b0;
            pin_d_reg <= 1'b0;
            evt_m_reg <= 1'b0;
            evt_s_reg <= 1'b0;
            bdm_m_reg <= 1'b0;
            bdm_reg <= 1'b0;
        end else begin
            pin_m_reg <= CH_PIN_IN;
            pin_s_reg <= pin_m_reg;
            pin_d_reg <= pin_s_reg;
            evt_m_reg <= EVENT_IN;
            evt_s_reg <= evt_m_reg;
            bdm_m_reg <= BDM_IN;
            bdm_reg <= bdm_m_reg;
        end
    end

    // Shared decodes of the value path
    wire [1:0] els_sel = sc_reg[`TCSV_SC_EDGE_LEVEL_SEL_HI:`TCSV_SC_EDGE_LEVEL_SEL_LO];
    // Pending pair loads on the strobe, or at once with enhanced features off
    wire upd_load = wpend_reg && (upd_wr || !ftm_en) && !bdm_reg;
    // The buffer is served only while a pair is open and debug is off
    wire use_rbuf = cap_mode && rlat_reg && !bdm_reg;

    // Status/control next state; a fresh event beats any clear
    always @* begin
        sc_next = sc_reg;
        armed_next = armed_reg;
        evt_since_rd_next = evt_since_rd_reg;
        // A read with the flag set arms the clear; a later event spoils it
        if (sc_rd && sc_reg[`TCSV_SC_FLAG]) begin
            armed_next = 1'b1;
            evt_since_rd_next = 1'b0;
        end else if (any_evt) begin
            evt_since_rd_next = 1'b1;
        end
        if (sc_wr) begin
            sc_next[`TCSV_SC_IE] = WDATA_IN[`TCSV_SC_IE];
            if (wp_dis)
                sc_next[5:2] = WDATA_IN[5:2];
            armed_next = 1'b0;
        end
        // Set wins over clear in one cycle, so no interrupt request is lost
        if (any_evt)
            sc_next[`TCSV_SC_FLAG] = 1'b1;
        else if (sc_wr && !WDATA_IN[`TCSV_SC_FLAG] && armed_reg && !evt_since_rd_reg)
            sc_next[`TCSV_SC_FLAG] = 1'b0;
        sc_next[1:0] = 2'b00;
    end

    // Status/control and module control registers
    always @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sc_reg <= `TCSV_SC_RST;
            ctrl_reg <= `TCSV_CTRL_RST;
            armed_reg <= 1'b0;
            evt_since_rd_reg <= 1'b0;
        end else begin
            if (WR_IN && ADDR_IN == `TCSV_OFF_CTRL)
                ctrl_reg <= WDATA_IN;
            sc_reg <= sc_next;
            armed_reg <= armed_next;
            evt_since_rd_reg <= evt_since_rd_next;
        end
    end

    // Read latch: frozen in debug, released by status/control writes
    always @* begin
        rbuf_next = rbuf_reg;
        rlat_next = rlat_reg;
        rlat_hi_next = rlat_hi_reg;
        if (sc_wr) begin
            rlat_next = 1'b0;
        end else if (cap_mode && v_rd && !bdm_reg) begin
            if (!rlat_reg) begin
                rbuf_next = val_reg;
                rlat_next = 1'b1;
                rlat_hi_next = vh_rd;
            end else if (vh_rd != rlat_hi_reg) begin
                // Only the other half closes the pair; a repeat read stays coherent
                rlat_next = 1'b0;
            end
        end
    end

    // Write coherency; writes are ignored in capture modes
    always @* begin
        wbuf_next = wbuf_reg;
        wh_next = wh_reg;
        wl_next = wl_reg;
        wpend_next = wpend_reg;
        if (upd_load)
            wpend_next = 1'b0;
        // Finished pair goes pending before any new byte, so that byte opens a new pair
        if (wh_reg && wl_reg && !bdm_reg) begin
            wpend_next = 1'b1;
            wh_next = 1'b0;
            wl_next = 1'b0;
        end
        // Debug value writes leave the latches alone, so a half pair survives them
        if (!cap_mode && (vh_wr || vl_wr) && !bdm_reg) begin
            if (vh_wr) begin
                wbuf_next[15:8] = WDATA_IN;
                wh_next = 1'b1;
            end else begin
                wbuf_next[7:0] = WDATA_IN;
                wl_next = 1'b1;
            end
        end else if (sc_wr && !ftm_en) begin
            wh_next = 1'b0;
            wl_next = 1'b0;
        end
    end

    // Live value: capture, direct debug writes or the pending buffer
    always @* begin
        val_next = val_reg;
        if (cap_evt)
            val_next = COUNT_IN[15:0];
        if (!cap_mode && bdm_reg && vh_wr)
            val_next[15:8] = WDATA_IN;
        if (!cap_mode && bdm_reg && vl_wr)
            val_next[7:0] = WDATA_IN;
        if (upd_load)
            val_next = wbuf_reg;
    end

    // Value, read latch and write coherency registers
    always @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            val_reg <= `TCSV_VAL_RST;
            rbuf_reg <= `TCSV_VAL_RST;
            rlat_reg <= 1'b0;
            rlat_hi_reg <= 1'b0;
            wbuf_reg <= `TCSV_VAL_RST;
            wh_reg <= 1'b0;
            wl_reg <= 1'b0;
            wpend_reg <= 1'b0;
        end else begin
            val_reg <= val_next;
            rbuf_reg <= rbuf_next;
            rlat_reg <= rlat_next;
            rlat_hi_reg <= rlat_hi_next;
            wbuf_reg <= wbuf_next;
            wh_reg <= wh_next;
            wl_reg <= wl_next;
            wpend_reg <= wpend_next;
        end
    end

    // Read mux; idle and unmapped slots return zero
    always @* begin
        rdata_next = 8'h00;
        if (RD_IN) begin
            if (ADDR_IN == OFF_SC)
                rdata_next = {sc_reg[7:2], 2'b00};
            else if (ADDR_IN == OFF_VH)
                rdata_next = use_rbuf ? rbuf_reg[15:8] : val_reg[15:8];
            else if (ADDR_IN == OFF_VL)
                rdata_next = use_rbuf ? rbuf_reg[7:0] : val_reg[7:0];
            else if (ADDR_IN == `TCSV_OFF_CTRL)
                rdata_next = ctrl_reg;
            else if (ADDR_IN == `TCSV_OFF_UPD)
                rdata_next = {7'h00, wpend_reg};
        end
    end

    // Channel status decodes
    always @* begin
        irq_next = sc_reg[`TCSV_SC_FLAG] && sc_reg[`TCSV_SC_IE];
        pin_en_next = (els_sel != 2'b00);
        cmp_action_next = 2'b00;
        cap_edges_next = 2'b00;
        if (cap_mode)
            cap_edges_next = els_sel;
        else
            cmp_action_next = els_sel;
    end

    // Registered outputs, so nothing combinational reaches a pin
    always @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RDATA_OUT <= 8'h00;
            IRQ_OUT <= 1'b0;
            MATCH_OUT <= {CNT_W{1'b0}};
            PIN_EN_OUT <= 1'b0;
            CAP_MODE_OUT <= 1'b0;
            CMP_ACTION_OUT <= 2'b00;
            CAP_EDGES_OUT <= 2'b00;
        end else begin
            RDATA_OUT <= rdata_next;
            IRQ_OUT <= irq_next;
            MATCH_OUT <= val_reg[CNT_W-1:0]; // Counter width is fixed at 16
            PIN_EN_OUT <= pin_en_next;
            CAP_MODE_OUT <= cap_mode;
            CMP_ACTION_OUT <= cmp_action_next;
            CAP_EDGES_OUT <= cap_edges_next;
        end
    end
endmodule // tcsv_channel
`default_nettype wire

/* File: tb/tcsv_channel_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tcsv_channel_checker #(
    parameter CNT_W = 16
) (
    // Clock, reset and register port
    input wire logic SYS_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic BDM_IN,
    input wire logic [7:0] RDATA_OUT,
    // Channel outputs
    input wire logic IRQ_OUT,
    input wire logic [CNT_W-1:0] MATCH_OUT,
    input wire logic PIN_EN_OUT,
    input wire logic CAP_MODE_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // Decoded strobes of channel 0
    wire sc_rd = RD_IN && ADDR_IN == 8'h05;
    wire sc_wr = WR_IN && ADDR_IN == 8'h05;
    wire v_wr = WR_IN && (ADDR_IN == 8'h06 || ADDR_IN == 8'h07);
    chk_rsvd_zero: assert property (sc_rd |=> RDATA_OUT[1:0] == 2'b00)
        else $error("reserved bits read as one");
    chk_irq_gate: assert property (sc_rd |=> IRQ_OUT == (RDATA_OUT[7] && RDATA_OUT[6]))
        else $error("interrupt differs from flag and enable");
    chk_irq_fall: assert property ($fell(IRQ_OUT) |-> $past(sc_wr, 2))
        else $error("interrupt dropped without status write");
    chk_pin_map: assert property (sc_rd |=> PIN_EN_OUT == (RDATA_OUT[3:2] != 2'b00))
        else $error("pin enable differs from edge select");
    chk_pin_wp: assert property ($changed(PIN_EN_OUT) |-> $past(sc_wr, 2))
        else $error("pin enable moved without status write");
    chk_unmapped_zero: assert property (RD_IN && ADDR_IN == 8'h40 |=> RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    chk_rd_idle: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data outside read slot");
    // Output mode writes land in the buffer, so the live value holds
    // Debug writes go straight through, so only writes seen outside debug count
    chk_match_buf: assert property (!CAP_MODE_OUT && v_wr && !$past(BDM_IN, 2)
        |=> ##1 $stable(MATCH_OUT))
        else $error("match value moved on byte write");
    cover property ($rose(IRQ_OUT));
    cover property (sc_rd ##1 RDATA_OUT[7]);
    cover property ($rose(CAP_MODE_OUT));
endmodule // tcsv_channel_checker
bind tcsv_channel tcsv_channel_checker #(.CNT_W(CNT_W)) u_chk (
    .SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN), .WR_IN(WR_IN),
    .RD_IN(RD_IN), .BDM_IN(BDM_IN), .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT),
    .MATCH_OUT(MATCH_OUT), .PIN_EN_OUT(PIN_EN_OUT), .CAP_MODE_OUT(CAP_MODE_OUT));
`default_nettype wire

/* File: tb/tcsv_channel_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tcsv_channel_tb;
    logic clk, rstn, wr, rd, ev, background_debug_active, pin, irq, pen, capm;
    logic [7:0] addr, wdata, rdata;
    logic [15:0] cnt, match;
    logic [1:0] act, edg;
    int num_errors = 0;
    int check_count = 0;
    // Plain cases: {write, address, data or expected read}
    logic [16:0] rows [13] = '{
        17'h00500, 17'h02001, 17'h02100, 17'h04000,
        17'h105ff, 17'h0057c,
        17'h12000, 17'h10500, 17'h0053c,
        17'h12003, 17'h02003, 17'h10514, 17'h00514};
    tcsv_channel #(.CH_INDEX(0), .CNT_W(16)) dut (
        .SYS_CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .COUNT_IN(cnt), .EVENT_IN(ev), .BDM_IN(background_debug_active),
        .CH_PIN_IN(pin), .IRQ_OUT(irq), .MATCH_OUT(match), .PIN_EN_OUT(pen),
        .CAP_MODE_OUT(capm), .CMP_ACTION_OUT(act), .CAP_EDGES_OUT(edg));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic ck(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bus cycles hold one idle slot after each strobe
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 ck(rdata, e);
    endtask
    task automatic evp;
        @(posedge clk);
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
        cyc(8);
    endtask
    task automatic pulse(input logic [15:0] c);
        @(posedge clk);
        cnt <= c;
        pin <= 1'b1;
        cyc(6);
        pin <= 1'b0;
        cyc(3);
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
        ck(irq, 1'b1);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        {rstn, wr, rd, ev, background_debug_active, pin} = '0;
        addr = '0;
        wdata = '0;
        cnt = 16'h1234;
        cyc(20);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][16]) wrt(rows[i][15:8], rows[i][7:0]);
            else rdr(rows[i][15:8], rows[i][7:0]);
        end
        ck({pen, capm, act}, 4'b1001);
        $display("rows done");
        wrt(8'h06, 8'h12);
        wrt(8'h07, 8'h34);
        ck(match, 16'h0000);
        rdr(8'h21, 8'h01);
        wrt(8'h21, 8'h00);
        cyc(2);
        ck(match, 16'h1234);
        $display("buffer done");
        evp;
        ck(irq, 1'b0);
        wrt(8'h05, 8'h54);
        rdr(8'h05, 8'hd4);
        wait_irq;
        wrt(8'h05, 8'hd4);
        rdr(8'h05, 8'hd4);
        evp;
        wrt(8'h05, 8'h54);
        rdr(8'h05, 8'hd4);
        wrt(8'h05, 8'h54);
        rdr(8'h05, 8'h54);
        cyc(2);
        ck(irq, 1'b0);
        $display("flag done");
        // Half a pair before debug, direct writes inside it
        wrt(8'h06, 8'haa);
        @(posedge clk) background_debug_active <= 1'b1;
        cyc(4);
        wrt(8'h06, 8'h56);
        wrt(8'h07, 8'h78);
        cyc(2);
        ck(match, 16'h5678);
        @(posedge clk) background_debug_active <= 1'b0;
        cyc(4);
        ck(match, 16'h5678);
        wrt(8'h07, 8'hbb);
        wrt(8'h21, 8'h00);
        cyc(2);
        ck(match, 16'haabb);
        $display("debug write done");
        wrt(8'h05, 8'h04);
        cyc(2);
        ck({capm, edg}, 3'b101);
        pulse(16'h0102);
        rdr(8'h06, 8'h01);
        pulse(16'h0304);
        rdr(8'h07, 8'h02);
        rdr(8'h06, 8'h03);
        pulse(16'h0506);
        wrt(8'h05, 8'h04);
        rdr(8'h07, 8'h06);
        @(posedge clk) background_debug_active <= 1'b1;
        cyc(4);
        pulse(16'h0708);
        wrt(8'h07, 8'hff);
        rdr(8'h07, 8'h08);
        @(posedge clk) background_debug_active <= 1'b0;
        cyc(4);
        rdr(8'h06, 8'h05);
        $display("capture done");
        // Reset in mid-run, then a write pair cut by a status write
        @(posedge clk) rstn <= 1'b0;
        cyc(3);
        rstn <= 1'b1;
        cyc(2);
        ck({irq, pen, capm}, 16'h0000);
        ck(match, 16'h0000);
        rdr(8'h05, 8'h00);
        rdr(8'h20, 8'h01);
        wrt(8'h06, 8'h11);
        wrt(8'h05, 8'h00);
        wrt(8'h07, 8'h22);
        cyc(4);
        ck(match, 16'h0000);
        wrt(8'h06, 8'h33);
        cyc(4);
        ck(match, 16'h3322);
        $display("reset done");
        conclude;
    end
endmodule // tcsv_channel_tb
`default_nettype wire
